//--- rtl/cis_top.sv
// Function
// R01 - Unknown self-test status keeps charging inhibited.
// R02 - A passed self-test moves the status to OK.
// R03 - A failed self-test blocks entry into pre-charge.
// R04 - Self-test is started and finished only inside cable check.
// R05 - Self-test proves monitor connection to both rails and earth, and measuring.
// R06 - A cable check precedes every pre-charge entry.
// R07 - Cable check voltage is min of 110 percent vehicle maximum and station maximum.
// R08 - Interface overvoltage protection is off during cable check.
// R09 - Short-circuit detection runs throughout cable check.
// R10 - Output current is capped at 5 A during cable check.
// R11 - Welding detection may run during cable check.
// R12 - Still invalid insulation at cable check end raises error shutdown.
// R13 - Insulation valid at or above 100 kilohm, fault below.
// R14 - Insulation fault in cable check raises error shutdown and fault message.
// R15 - Valid insulation must be reachable within 38 s of cable check start.
// R16 - Single-rail and both-rail thresholds; band between may be either.
// R17 - Charging insulation fault raises error shutdown within 10 s, with message.
// R18 - Insulation state is reported to the vehicle periodically.
// R19 - Pilot leaving C or D triggers emergency shutdown within 10 ms.
// R20 - At session start with pilot A or B, cable above 60 V ends session.
// R21 - Emergency shutdown stops the pilot oscillator.
// R22 - After emergency, current below 5 A and output off within 30 ms.
// R23 - Shutdowns stay latched until a new supply session begins.
//
// Local design decisions: the plain strobed port and the register addresses.
module cis_top #(
  parameter logic [cis_pkg::CNT_W-1:0] CC_TIMEOUT_CYC = cis_pkg::CNT_W'(cis_pkg::CC_TIMEOUT_CYC),
  parameter logic [cis_pkg::CNT_W-1:0] REPORT_CYC     = cis_pkg::CNT_W'(cis_pkg::REPORT_CYC)
) (
  // Clock and reset.
  input  wire logic        ref_clk_in,
  input  wire logic        rst_in,
  // Register port.
  input  wire logic [7:0]  addr_in,
  input  wire logic [31:0] wdata_in,
  input  wire logic        wr_in,
  input  wire logic        rd_in,
  output logic      [31:0] rdata_out,
  // Pilot line and cable measurement.
  input  wire logic [2:0]  pilot_state_in,
  input  wire logic [15:0] cable_volt_in,
  output logic             pilot_osc_out,
  // Insulation monitor.
  input  wire logic        imon_test_done_in,
  input  wire logic        imon_test_pass_in,
  input  wire logic        imon_meas_done_in,
  input  wire logic [15:0] imon_rpos_kohm_in,
  input  wire logic [15:0] imon_rneg_kohm_in,
  output logic             imon_test_start_out,
  output logic             imon_enable_out,
  // Power stage.
  input  wire logic        short_det_in,
  input  wire logic        precharge_done_in,
  output logic      [15:0] volt_setpt_out,
  output logic      [15:0] curr_limit_out,
  output logic             output_en_out,
  output logic             ovp_en_out,
  output logic             short_det_en_out,
  output logic             weld_det_en_out,
  // Status toward the vehicle and firmware.
  output logic             charge_allow_out,
  output logic             precharge_allow_out,
  output logic             error_shutdown_out,
  output logic             emergency_out,
  output logic             ins_report_out,
  output logic             ins_valid_out,
  output logic             fault_msg_out
);

  // Smaller of two unsigned values.
  function automatic logic [15:0] min16(input logic [15:0] a, input logic [15:0] b);
    min16 = (a < b) ? a : b;
  endfunction

  cis_pkg::cis_state_t        state_q, state_d;
  cis_pkg::cis_selftest_t     st_q, st_d;
  logic [cis_pkg::CNT_W-1:0]  cc_cnt_q, cc_cnt_d;
  logic [cis_pkg::CNT_W-1:0]  rep_cnt_q, rep_cnt_d;
  logic                       meas_q, meas_d;
  logic                       cd_seen_q, cd_seen_d;
  logic                       err_q, err_d;
  logic                       emg_q, emg_d;
  logic                       weld_en_q, weld_en_d;
  logic [15:0]                ev_vmax_q, ev_vmax_d;
  logic [15:0]                se_vmax_q, se_vmax_d;
  logic [15:0]                ireq_q, ireq_d;
  logic [15:0]                setpt_q, setpt_d;
  logic [15:0]                ilim_q, ilim_d;
  logic                       tstart_q, tstart_d;
  logic                       fmsg_q, fmsg_d;
  logic                       rep_q, rep_d;
  logic                       insv_q, insv_d;
  logic [31:0]                rdata_q, rdata_d;
  logic                       go_session, go_cc, go_stop;
  logic                       ins_fault, ins_valid, pilot_cd, pilot_ab;
  logic [31:0]                ev_scaled;

  // Command pulses written to the control register.
  assign go_session = wr_in && (addr_in == cis_pkg::ADDR_CTRL) && wdata_in[cis_pkg::CTRL_SESSION];
  assign go_cc      = wr_in && (addr_in == cis_pkg::ADDR_CTRL) && wdata_in[cis_pkg::CTRL_CC_GO];
  assign go_stop    = wr_in && (addr_in == cis_pkg::ADDR_CTRL) && wdata_in[cis_pkg::CTRL_STOP];

  // Either rail below the floor is a fault; one threshold covers both cases.
  assign ins_fault = meas_q && ((imon_rpos_kohm_in < cis_pkg::INS_MIN_KOHM)
                             || (imon_rneg_kohm_in < cis_pkg::INS_MIN_KOHM)); // see R13 see R16
  assign ins_valid = (st_q == cis_pkg::CIS_ST_OK) && meas_q && !ins_fault; // see R12
  assign pilot_cd  = (pilot_state_in == cis_pkg::PILOT_C) || (pilot_state_in == cis_pkg::PILOT_D);
  assign pilot_ab  = (pilot_state_in == cis_pkg::PILOT_A) || (pilot_state_in == cis_pkg::PILOT_B);
  assign ev_scaled = ({16'h0000, ev_vmax_q} * cis_pkg::CC_PCT) / cis_pkg::PCT_DIV;

  // Next-state logic for the supply sequence, latches and outputs.
  always_comb
  begin
    state_d   = state_q;
    st_d      = st_q;
    cc_cnt_d  = cc_cnt_q;
    rep_cnt_d = rep_cnt_q;
    meas_d    = meas_q;
    cd_seen_d = cd_seen_q;
    err_d     = err_q;
    emg_d     = emg_q;
    tstart_d  = 1'b0;
    fmsg_d    = 1'b0;
    rep_d     = 1'b0;
    case (state_q)
      cis_pkg::CIS_IDLE:
      begin
        if (go_session)
        begin
          err_d   = 1'b0; // see R23
          emg_d   = 1'b0;
          state_d = cis_pkg::CIS_VCHECK;
        end
      end
      cis_pkg::CIS_VCHECK:
      begin
        if (pilot_ab && (cable_volt_in > cis_pkg::SAFE_V))
        begin
          err_d   = 1'b1; // see R20
          state_d = cis_pkg::CIS_SHUT;
        end
        else if (go_cc && !go_stop)
        begin
          st_d      = cis_pkg::CIS_ST_UNKNOWN; // see R01
          meas_d    = 1'b0;
          cc_cnt_d  = '0;
          tstart_d  = 1'b1; // see R04
          cd_seen_d = 1'b0;
          state_d   = cis_pkg::CIS_CCHECK;
        end
      end
      cis_pkg::CIS_CCHECK:
      begin
        cc_cnt_d = cc_cnt_q + 1'b1;
        if (imon_test_done_in)
        begin
          // A pass means both rails and earth are wired and measured.
          st_d = imon_test_pass_in ? cis_pkg::CIS_ST_OK : cis_pkg::CIS_ST_FAILED; // see R02 see R05
        end
        if (imon_meas_done_in)
        begin
          meas_d = 1'b1;
        end
        if (short_det_in)
        begin
          err_d   = 1'b1; // see R09
          state_d = cis_pkg::CIS_SHUT;
        end
        else if (ins_fault)
        begin
          err_d   = 1'b1; // see R14
          fmsg_d  = 1'b1;
          state_d = cis_pkg::CIS_SHUT;
        end
        else if (st_q == cis_pkg::CIS_ST_FAILED)
        begin
          err_d   = 1'b1; // see R03
          state_d = cis_pkg::CIS_SHUT;
        end
        else if (ins_valid)
        begin
          state_d = cis_pkg::CIS_PRECH; // see R06
        end
        else if (cc_cnt_q >= CC_TIMEOUT_CYC - 1'b1)
        begin
          err_d   = 1'b1; // see R12 see R15
          state_d = cis_pkg::CIS_SHUT;
        end
      end
      cis_pkg::CIS_PRECH, cis_pkg::CIS_CHARGE:
      begin
        if (imon_meas_done_in)
        begin
          meas_d = 1'b1;
        end
        if (state_q == cis_pkg::CIS_PRECH && precharge_done_in)
        begin
          state_d = cis_pkg::CIS_CHARGE;
        end
        if (ins_fault)
        begin
          err_d   = 1'b1; // see R17
          fmsg_d  = 1'b1;
          state_d = cis_pkg::CIS_SHUT;
        end
      end
      cis_pkg::CIS_SHUT:
      begin
        if (go_session)
        begin
          err_d   = 1'b0; // see R23
          emg_d   = 1'b0;
          state_d = cis_pkg::CIS_VCHECK;
        end
      end
      default:
      begin
        state_d = cis_pkg::CIS_IDLE;
      end
    endcase
    // Once the pilot has reached C or D, any other code is an emergency.
    if (state_q == cis_pkg::CIS_CCHECK || state_q == cis_pkg::CIS_PRECH
        || state_q == cis_pkg::CIS_CHARGE)
    begin
      if (pilot_cd)
      begin
        cd_seen_d = 1'b1;
      end
      else if (cd_seen_q)
      begin
        emg_d   = 1'b1; // see R19
        state_d = cis_pkg::CIS_SHUT;
      end
    end
    // A firmware stop ends a running session without a fault.
    if (go_stop && state_q != cis_pkg::CIS_SHUT)
    begin
      state_d = cis_pkg::CIS_IDLE;
    end
    // Periodic insulation report while a session is open.
    if (state_q == cis_pkg::CIS_IDLE)
    begin
      rep_cnt_d = '0;
    end
    else if (rep_cnt_q >= REPORT_CYC - 1'b1)
    begin
      rep_cnt_d = '0;
      rep_d     = 1'b1; // see R18
    end
    else
    begin
      rep_cnt_d = rep_cnt_q + 1'b1;
    end
    insv_d = ins_valid;
  end

  // Register file writes and the output drive values.
  always_comb
  begin
    weld_en_d = weld_en_q;
    ev_vmax_d = ev_vmax_q;
    se_vmax_d = se_vmax_q;
    ireq_d    = ireq_q;
    if (wr_in)
    begin
      case (addr_in)
        cis_pkg::ADDR_CTRL:   weld_en_d = wdata_in[cis_pkg::CTRL_WELD_EN];
        cis_pkg::ADDR_EVVMAX: ev_vmax_d = wdata_in[15:0];
        cis_pkg::ADDR_SEVMAX: se_vmax_d = wdata_in[15:0];
        cis_pkg::ADDR_IREQ:   ireq_d    = wdata_in[15:0];
        default:              ireq_d    = ireq_q;
      endcase
    end
    setpt_d = 16'h0000;
    ilim_d  = 16'h0000;
    if (state_d == cis_pkg::CIS_CCHECK)
    begin
      setpt_d = min16((ev_scaled > 32'h0000FFFF) ? 16'hFFFF : ev_scaled[15:0], se_vmax_q); // see R07
      ilim_d  = min16(ireq_q, cis_pkg::CC_IMAX_A); // see R10
    end
    else if (state_d == cis_pkg::CIS_PRECH || state_d == cis_pkg::CIS_CHARGE)
    begin
      setpt_d = se_vmax_q;
      ilim_d  = ireq_q;
    end
    // A shutdown state drives zero current at once.
  end

  // Read data stand only in the cycle after the read strobe.
  always_comb
  begin
    rdata_d = 32'h00000000;
    if (rd_in)
    begin
      case (addr_in)
        cis_pkg::ADDR_CTRL:   rdata_d = {29'h00000000, weld_en_q, 2'h0};
        cis_pkg::ADDR_EVVMAX: rdata_d = {16'h0000, ev_vmax_q};
        cis_pkg::ADDR_SEVMAX: rdata_d = {16'h0000, se_vmax_q};
        cis_pkg::ADDR_IREQ:   rdata_d = {16'h0000, ireq_q};
        cis_pkg::ADDR_STATUS: rdata_d = {18'h00000, ins_fault, ins_valid, emg_q, err_q,
                                         st_q, meas_q, state_q};
        cis_pkg::ADDR_INS:    rdata_d = {imon_rneg_kohm_in, imon_rpos_kohm_in};
        cis_pkg::ADDR_SETPT:  rdata_d = {ilim_q, setpt_q};
        default:              rdata_d = 32'h00000000;
      endcase
    end
  end

  // State registers.
  always_ff @(posedge ref_clk_in)
  begin
    if (rst_in)
    begin
      state_q   <= cis_pkg::CIS_IDLE;
      st_q      <= cis_pkg::CIS_ST_UNKNOWN;
      cc_cnt_q  <= '0;
      rep_cnt_q <= '0;
      meas_q    <= 1'b0;
      cd_seen_q <= 1'b0;
      err_q     <= 1'b0;
      emg_q     <= 1'b0;
      weld_en_q <= 1'b0;
      ev_vmax_q <= cis_pkg::RST_VMAX;
      se_vmax_q <= cis_pkg::RST_VMAX;
      ireq_q    <= cis_pkg::RST_IREQ;
      setpt_q   <= 16'h0000;
      ilim_q    <= 16'h0000;
      tstart_q  <= 1'b0;
      fmsg_q    <= 1'b0;
      rep_q     <= 1'b0;
      insv_q    <= 1'b0;
      rdata_q   <= 32'h00000000;
    end
    else
    begin
      state_q   <= state_d;
      st_q      <= st_d;
      cc_cnt_q  <= cc_cnt_d;
      rep_cnt_q <= rep_cnt_d;
      meas_q    <= meas_d;
      cd_seen_q <= cd_seen_d;
      err_q     <= err_d;
      emg_q     <= emg_d;
      weld_en_q <= weld_en_d;
      ev_vmax_q <= ev_vmax_d;
      se_vmax_q <= se_vmax_d;
      ireq_q    <= ireq_d;
      setpt_q   <= setpt_d;
      ilim_q    <= ilim_d;
      tstart_q  <= tstart_d;
      fmsg_q    <= fmsg_d;
      rep_q     <= rep_d;
      insv_q    <= insv_d;
      rdata_q   <= rdata_d;
    end
  end

  // Output drive, decoded from registered state.
  assign rdata_out           = rdata_q;
  assign volt_setpt_out      = setpt_q;
  assign curr_limit_out      = ilim_q; // see R22
  assign imon_test_start_out = tstart_q;
  assign fault_msg_out       = fmsg_q;
  assign ins_report_out      = rep_q;
  assign ins_valid_out       = insv_q;
  assign error_shutdown_out  = err_q;
  assign emergency_out       = emg_q;
  assign pilot_osc_out       = !emg_q && (state_q == cis_pkg::CIS_CCHECK || state_q == cis_pkg::CIS_PRECH
                                          || state_q == cis_pkg::CIS_CHARGE); // see R21
  assign output_en_out       = (state_q == cis_pkg::CIS_CCHECK || state_q == cis_pkg::CIS_PRECH
                                || state_q == cis_pkg::CIS_CHARGE); // see R22
  assign imon_enable_out     = !emg_q && (state_q != cis_pkg::CIS_IDLE);
  assign ovp_en_out          = (state_q != cis_pkg::CIS_CCHECK); // see R08
  assign short_det_en_out    = (state_q == cis_pkg::CIS_CCHECK); // see R09
  assign weld_det_en_out     = (state_q == cis_pkg::CIS_CCHECK) && weld_en_q; // see R11
  assign precharge_allow_out = (state_q == cis_pkg::CIS_PRECH) && (st_q == cis_pkg::CIS_ST_OK); // see R03
  assign charge_allow_out    = (state_q == cis_pkg::CIS_CHARGE) && (st_q == cis_pkg::CIS_ST_OK); // see R01

endmodule

//--- include/cis_pkg.sv
package cis_pkg;

  // Clock rate and derived cycle counts.
  localparam longint unsigned CLK_HZ         = 200_000_000;
  localparam longint unsigned CC_TIMEOUT_S   = 38;
  localparam longint unsigned CC_TIMEOUT_CYC = CC_TIMEOUT_S * CLK_HZ;
  localparam longint unsigned REPORT_MS      = 100;
  localparam longint unsigned REPORT_CYC     = REPORT_MS * CLK_HZ / 1000;
  localparam int              CNT_W          = 34;

  // Electrical thresholds, in kilohm, ampere, volt and percent.
  localparam logic [15:0] INS_MIN_KOHM = 16'h0064;
  localparam logic [15:0] CC_IMAX_A    = 16'h0005;
  localparam logic [15:0] SAFE_V       = 16'h003C;
  localparam logic [31:0] CC_PCT       = 32'h0000006E;
  localparam logic [31:0] PCT_DIV      = 32'h00000064;

  // Pilot state codes.
  localparam logic [2:0] PILOT_A = 3'h0;
  localparam logic [2:0] PILOT_B = 3'h1;
  localparam logic [2:0] PILOT_C = 3'h2;
  localparam logic [2:0] PILOT_D = 3'h3;

  // Register byte addresses.
  localparam logic [7:0] ADDR_CTRL   = 8'h00;
  localparam logic [7:0] ADDR_EVVMAX = 8'h04;
  localparam logic [7:0] ADDR_SEVMAX = 8'h08;
  localparam logic [7:0] ADDR_IREQ   = 8'h0C;
  localparam logic [7:0] ADDR_STATUS = 8'h10;
  localparam logic [7:0] ADDR_INS    = 8'h14;
  localparam logic [7:0] ADDR_SETPT  = 8'h18;

  // Control register bit positions.
  localparam int CTRL_SESSION = 0;
  localparam int CTRL_CC_GO   = 1;
  localparam int CTRL_WELD_EN = 2;
  localparam int CTRL_STOP    = 3;

  // Values after reset.
  localparam logic [15:0] RST_VMAX = 16'h0000;
  localparam logic [15:0] RST_IREQ = 16'h0000;

  // Supply sequence states.
  typedef enum logic [5:0] {
    CIS_IDLE   = 6'h01,
    CIS_VCHECK = 6'h02,
    CIS_CCHECK = 6'h04,
    CIS_PRECH  = 6'h08,
    CIS_CHARGE = 6'h10,
    CIS_SHUT   = 6'h20
  } cis_state_t;

  // Functional status of the insulation monitor.
  typedef enum logic [2:0] {
    CIS_ST_UNKNOWN = 3'h1,
    CIS_ST_OK      = 3'h2,
    CIS_ST_FAILED  = 3'h4
  } cis_selftest_t;

endpackage

//--- bench/cis_monitor.sv
module cis_monitor (
  // Watched ports.
  input wire logic        ref_clk_in,
  input wire logic        rst_in,
  input wire logic [7:0]  addr_in,
  input wire logic [31:0] wdata_in,
  input wire logic        wr_in,
  input wire logic        rd_in,
  input wire logic [31:0] rdata_out,
  input wire logic [2:0]  pilot_state_in,
  input wire logic        pilot_osc_out,
  input wire logic        imon_test_start_out,
  input wire logic        imon_enable_out,
  input wire logic [15:0] curr_limit_out,
  input wire logic        output_en_out,
  input wire logic        ovp_en_out,
  input wire logic        short_det_en_out,
  input wire logic        charge_allow_out,
  input wire logic        precharge_allow_out,
  input wire logic        error_shutdown_out,
  input wire logic        emergency_out,
  input wire logic        ins_report_out,
  input wire logic        ins_valid_out,
  input wire logic        fault_msg_out
);
  // A vehicle that is ready shows pilot C or D; a write of the session bit opens a new session.
  wire logic cd  = (pilot_state_in == cis_pkg::PILOT_C) || (pilot_state_in == cis_pkg::PILOT_D);
  wire logic ses = wr_in && (addr_in == cis_pkg::ADDR_CTRL) && wdata_in[cis_pkg::CTRL_SESSION];

  default clocking @(posedge ref_clk_in); endclocking
  default disable iff (rst_in);

  cc_limits_a: assert property (
    imon_test_start_out |-> !ovp_en_out && short_det_en_out && (curr_limit_out <= cis_pkg::CC_IMAX_A))
    else $error("Cable check output limits broken.");
  start_pulse_a: assert property (imon_test_start_out |=> !imon_test_start_out)
    else $error("Self-test start longer than one cycle.");
  pre_gate_a: assert property (
    precharge_allow_out |-> ins_valid_out && !error_shutdown_out && !emergency_out)
    else $error("Pre-charge allowed without valid insulation.");
  charge_gate_a: assert property (charge_allow_out |-> ins_valid_out && !error_shutdown_out)
    else $error("Charging allowed in a bad state.");
  estop_out_a: assert property (
    $rose(emergency_out) |-> !pilot_osc_out && !output_en_out && !imon_enable_out &&
      (curr_limit_out < cis_pkg::CC_IMAX_A))
    else $error("Emergency did not stop the output.");
  pilot_loss_a: assert property ((output_en_out && cd) ##1 !cd |=> emergency_out)
    else $error("Pilot loss gave no emergency.");
  fault_err_a: assert property ($rose(fault_msg_out) |-> ##[0:1] error_shutdown_out)
    else $error("Fault message without error shutdown.");
  fault_pulse_a: assert property (fault_msg_out |=> !fault_msg_out)
    else $error("Fault message longer than one cycle.");
  report_pulse_a: assert property (ins_report_out |=> !ins_report_out)
    else $error("Report longer than one cycle.");
  err_latch_a: assert property ((error_shutdown_out || emergency_out) && !ses |=>
    (error_shutdown_out || emergency_out))
    else $error("Shutdown released without a new session.");
  rdata_idle_a: assert property (!$past(rd_in) |-> rdata_out == 32'h00000000)
    else $error("Read data outside the read answer cycle.");
endmodule

bind cis_top cis_monitor u_mon (.ref_clk_in, .rst_in, .addr_in, .wdata_in, .wr_in, .rd_in, .rdata_out,
  .pilot_state_in, .pilot_osc_out, .imon_test_start_out, .imon_enable_out, .curr_limit_out, .output_en_out,
  .ovp_en_out, .short_det_en_out, .charge_allow_out, .precharge_allow_out, .error_shutdown_out,
  .emergency_out, .ins_report_out, .ins_valid_out, .fault_msg_out);

//--- bench/cis_ev_model.sv
module cis_ev_model (
  // Clock and reset.
  input  wire logic       clk_in,
  input  wire logic       rst_in,
  // Goal from the bench, slow answer select and the station oscillator.
  input  wire logic [2:0] goal_in,
  input  wire logic       slow_in,
  input  wire logic       osc_in,
  // Pilot state seen by the station.
  output logic      [2:0] pilot_out
);
  logic [2:0] pilot_q;
  logic [2:0] wait_q;
  logic       osc_q;

  // The pilot follows the goal after one or four cycles; a stopped oscillator sends a ready vehicle to B.
  always_ff @(posedge clk_in)
  begin
    osc_q <= osc_in;
    if (rst_in)
    begin
      pilot_q <= cis_pkg::PILOT_A;
      wait_q  <= 3'h0;
    end
    else if (osc_q && !osc_in && (pilot_q == cis_pkg::PILOT_C || pilot_q == cis_pkg::PILOT_D))
      pilot_q <= cis_pkg::PILOT_B;
    else if (goal_in == pilot_q)
      wait_q <= 3'h0;
    else if (wait_q >= (slow_in ? 3'h3 : 3'h0))
    begin
      pilot_q <= goal_in;
      wait_q  <= 3'h0;
    end
    else
      wait_q <= wait_q + 3'h1;
  end

  assign pilot_out = pilot_q;
endmodule

//--- bench/cis_top_bench.sv
module cis_top_bench;
  timeunit 1ns;
  timeprecision 1ps;

  // Stimulus, outputs and bookkeeping.
  logic ref_clk_in = 1'b0, rst_in = 1'b1, wr_in = 1'b0, rd_in = 1'b0, short_det_in = 1'b0;
  logic imon_test_done_in = 1'b0, imon_test_pass_in = 1'b0, imon_meas_done_in = 1'b0, precharge_done_in = 1'b0;
  logic [7:0]  addr_in = 8'h00;
  logic [31:0] wdata_in = 32'h00000000, rdata_out;
  logic [15:0] cable_volt_in = 16'h003C, imon_rpos_kohm_in = 16'h0000, imon_rneg_kohm_in = 16'h0000;
  logic [15:0] volt_setpt_out, curr_limit_out;
  logic [2:0]  goal = cis_pkg::PILOT_A;
  wire  [2:0]  pilot_state_in;
  logic slow = 1'b0, pilot_osc_out, imon_test_start_out, imon_enable_out, output_en_out, ovp_en_out;
  logic short_det_en_out, weld_det_en_out, charge_allow_out, precharge_allow_out, error_shutdown_out;
  logic emergency_out, ins_report_out, ins_valid_out, fault_msg_out;
  logic seen_msg = 1'b0, seen_rep = 1'b0, seen_start = 1'b0, seen_pre = 1'b0;
  int   n_errors = 0, tests_run = 0;

  cis_top #(.CC_TIMEOUT_CYC(34'h0000000C8), .REPORT_CYC(34'h000000010)) dut (.ref_clk_in, .rst_in, .addr_in,
    .wdata_in, .wr_in, .rd_in, .rdata_out, .pilot_state_in, .cable_volt_in, .pilot_osc_out, .imon_test_done_in,
    .imon_test_pass_in, .imon_meas_done_in, .imon_rpos_kohm_in, .imon_rneg_kohm_in, .imon_test_start_out,
    .imon_enable_out, .short_det_in, .precharge_done_in, .volt_setpt_out, .curr_limit_out, .output_en_out,
    .ovp_en_out, .short_det_en_out, .weld_det_en_out, .charge_allow_out, .precharge_allow_out,
    .error_shutdown_out, .emergency_out, .ins_report_out, .ins_valid_out, .fault_msg_out);

  cis_ev_model u_ev (.clk_in(ref_clk_in), .rst_in(rst_in), .goal_in(goal), .slow_in(slow),
    .osc_in(pilot_osc_out), .pilot_out(pilot_state_in));

  // Clock at 200 MHz.
  always #2.5 ref_clk_in = ~ref_clk_in;

  // Sticky flags catch one-cycle pulses between checks.
  always @(posedge ref_clk_in)
  begin
    if (fault_msg_out) seen_msg = 1'b1;
    if (ins_report_out) seen_rep = 1'b1;
    if (imon_test_start_out) seen_start = 1'b1;
    if (precharge_allow_out) seen_pre = 1'b1;
  end

  task automatic print_verdict;
    $display("Checks %0d, errors %0d", tests_run, n_errors);
    if (n_errors == 0 && tests_run > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge ref_clk_in);
    #1;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk_in);
    addr_in <= a;
    wdata_in <= d;
    wr_in <= 1'b1;
    @(posedge ref_clk_in);
    wr_in <= 1'b0;
    #1;
  endtask

  // Read one register and compare the masked answer.
  task automatic rd_chk(input string what, input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    @(posedge ref_clk_in);
    addr_in <= a;
    rd_in <= 1'b1;
    @(posedge ref_clk_in);
    rd_in <= 1'b0;
    #1;
    chk(what, rdata_out & m, e);
  endtask

  function automatic logic sig(input int s);
    case (s)
      0: return precharge_allow_out;
      1: return charge_allow_out;
      2: return error_shutdown_out;
      default: return emergency_out;
    endcase
  endfunction

  // Bounded wait for a status output; running out of time ends the run.
  task automatic wait_hi(input int s, input int lim, output int n);
    n = 0;
    while (sig(s) !== 1'b1 && n < lim)
    begin
      tick(1);
      n++;
    end
    if (n >= lim)
    begin
      n_errors++;
      $display("[ERR] wait %0d expected 1 seen timeout", s);
      print_verdict();
    end
  endtask

  task automatic pulse_test(input logic p);
    @(posedge ref_clk_in);
    imon_test_done_in <= 1'b1;
    imon_test_pass_in <= p;
    @(posedge ref_clk_in);
    imon_test_done_in <= 1'b0;
    #1;
  endtask

  task automatic meas(input logic [15:0] rp, input logic [15:0] rn);
    @(posedge ref_clk_in);
    imon_rpos_kohm_in <= rp;
    imon_rneg_kohm_in <= rn;
    imon_meas_done_in <= 1'b1;
    @(posedge ref_clk_in);
    imon_meas_done_in <= 1'b0;
    #1;
  endtask

  // Opens a session at 60 V with pilot B, then enters cable check and checks its outputs.
  task automatic start_cc(input logic [31:0] ev, input logic [31:0] se, input logic [31:0] ir, input logic [31:0] c);
    logic [31:0] sp;
    sp = (ev * cis_pkg::CC_PCT) / cis_pkg::PCT_DIV;
    @(posedge ref_clk_in);
    goal <= cis_pkg::PILOT_B;
    cable_volt_in <= 16'h003C;
    tick(2);
    wr(cis_pkg::ADDR_EVVMAX, ev);
    wr(cis_pkg::ADDR_SEVMAX, se);
    wr(cis_pkg::ADDR_IREQ, ir);
    wr(cis_pkg::ADDR_CTRL, 32'h00000001);
    chk("latch cleared", {error_shutdown_out, emergency_out}, 32'h0);
    goal <= cis_pkg::PILOT_C;
    seen_start = 1'b0;
    seen_pre = 1'b0;
    seen_msg = 1'b0;
    wr(cis_pkg::ADDR_CTRL, c);
    tick(2);
    chk("test start", seen_start, 32'h1);
    chk("setpoint", volt_setpt_out, (sp < se) ? sp : se);
    chk("limit", curr_limit_out, (ir < 32'h5) ? ir : 32'h5);
    chk("ovp off", ovp_en_out, 32'h0);
  endtask

  task automatic sc_reset;
    chk("ovp reset", ovp_en_out, 32'h1);
    chk("no charge", charge_allow_out, 32'h0);
    rd_chk("status reset", cis_pkg::ADDR_STATUS, 32'h0000003F, 32'h00000001);
    rd_chk("unmapped", 8'h1C, 32'hFFFFFFFF, 32'h00000000);
  endtask

  task automatic sc_volt_init;
    @(posedge ref_clk_in);
    goal <= cis_pkg::PILOT_B;
    cable_volt_in <= 16'h003D;
    tick(2);
    wr(cis_pkg::ADDR_CTRL, 32'h00000001);
    tick(2);
    rd_chk("high cable volt", cis_pkg::ADDR_STATUS, 32'h0000043F, 32'h00000420);
  endtask

  // Full path to charging, then an insulation fault or a pilot loss with the given code.
  task automatic sc_charge(input logic [2:0] loss, input logic fault);
    int n;
    start_cc(32'h00000190, 32'h000001F4, 32'h0000000A, 32'h00000006);
    chk("weld enable", weld_det_en_out, 32'h1);
    pulse_test(1'b1);
    rd_chk("selftest ok", cis_pkg::ADDR_STATUS, 32'h00000380, 32'h00000100);
    meas(16'h0064, 16'h0064);
    wait_hi(0, 4, n);
    @(posedge ref_clk_in);
    precharge_done_in <= 1'b1;
    @(posedge ref_clk_in);
    precharge_done_in <= 1'b0;
    wait_hi(1, 4, n);
    seen_rep = 1'b0;
    tick(20);
    chk("report", seen_rep, 32'h1);
    if (fault)
    begin
      meas(16'h0063, 16'h0096);
      wait_hi(2, 3, n);
      tick(1);
      chk("charge fault msg", seen_msg, 32'h1);
      tick(5);
      chk("error held", error_shutdown_out, 32'h1);
    end
    else
    begin
      slow = (loss == cis_pkg::PILOT_B);
      goal <= loss;
      wait_hi(3, 8, n);
      chk("osc off", pilot_osc_out, 32'h0);
      chk("output off", output_en_out, 32'h0);
      slow = 1'b0;
    end
  endtask

  task automatic sc_cc_fail;
    int n;
    start_cc(32'h000001F4, 32'h000001F4, 32'h00000003, 32'h00000002);
    pulse_test(1'b0);
    rd_chk("selftest failed", cis_pkg::ADDR_STATUS, 32'h00000380, 32'h00000200);
    meas(16'h00C8, 16'h00C8);
    wait_hi(2, 210, n);
    chk("no precharge", seen_pre, 32'h0);
  endtask

  task automatic sc_cc_timeout;
    int n;
    start_cc(32'h00000064, 32'h00000064, 32'h00000005, 32'h00000002);
    wait_hi(2, 260, n);
    chk("timeout cycle", (n >= 190 && n <= 200), 32'h1);
  endtask

  task automatic sc_cc_fault_short(input logic sh);
    int n;
    start_cc(32'h00000064, 32'h00000064, 32'h00000005, 32'h00000002);
    pulse_test(1'b1);
    if (sh)
      short_det_in <= 1'b1;
    else
      meas(16'h0096, 16'h0063);
    wait_hi(2, 4, n);
    tick(1);
    chk("cc fault msg", seen_msg, {31'h0, !sh});
    short_det_in <= 1'b0;
  endtask

  // Main sequence.
  initial
  begin
    repeat (4) @(posedge ref_clk_in);
    rst_in <= 1'b0;
    tick(1);
    sc_reset();
    sc_volt_init();
    sc_charge(cis_pkg::PILOT_A, 1'b1);
    sc_charge(cis_pkg::PILOT_A, 1'b0);
    sc_charge(cis_pkg::PILOT_B, 1'b0);
    sc_charge(3'h4, 1'b0);
    sc_charge(3'h7, 1'b0);
    sc_cc_fail();
    sc_cc_timeout();
    sc_cc_fault_short(1'b0);
    sc_cc_fault_short(1'b1);
    print_verdict();
  end
endmodule
